// [design/eloh_event_log.sv]
// event log handshake: queue, block area, sequence/acknowledge registers
`timescale 1ns/1ns
module eloh_event_log import eloh_pkg::*; #(
  parameter int MAX_BLOCKS = ELOH_DEF_MAX_BLOCKS,
  parameter int FIFO_DEPTH = ELOH_DEF_FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // event producer
  input wire logic i_evt_valid,
  input wire eloh_event_s i_evt,
  output logic o_evt_ready,
  // register port, word addressed
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  output logic o_reg_ack,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_wr_refused,
  // status
  output logic o_idle,
  output logic o_transfer_state,
  output logic [15:0] o_batch_blocks,
  output logic o_ack_mismatch
);
  localparam int AREA_WORDS = MAX_BLOCKS * ELOH_WORDS_PER_BLOCK;
  localparam int BW = $clog2(MAX_BLOCKS + 1);
  localparam int WW = (AREA_WORDS > 1) ? $clog2(AREA_WORDS) : 1;
  localparam logic [15:0] AREA_LEN = 16'(AREA_WORDS);
  localparam logic [BW-1:0] BLK_LIMIT = BW'(MAX_BLOCKS);

  generate
    if (MAX_BLOCKS < 1 || AREA_WORDS + 7 > 65536) begin : g_bad_blocks
      $error("eloh_event_log: block area does not fit the register space");
    end
  endgenerate

  // ---------------------------------------------------------------------
  // event queue and encoder
  // ---------------------------------------------------------------------
  logic q_valid;
  eloh_event_s q_event;
  logic q_pop;
  eloh_block_s enc_block;

  eloh_fifo #(
    .WIDTH($bits(eloh_event_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_queue (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_evt_valid),
    .i_in_data(i_evt),
    .o_in_ready(o_evt_ready),
    .o_out_valid(q_valid),
    .o_out_data(q_event),
    .i_out_ready(q_pop)
  );

  eloh_encoder u_encoder (
    .i_event(q_event),
    .o_block(enc_block)
  );

  // ---------------------------------------------------------------------
  // handshake registers
  // ---------------------------------------------------------------------
  eloh_state_e state;
  eloh_state_e next_state;
  logic [15:0] seq_counter;
  logic [15:0] blk_count;
  logic [15:0] acknowledged_sequence;
  logic [15:0] acknowledged_block_count;
  logic [BW-1:0] fill_count;
  logic handshake_idle;
  logic area_full;
  logic acknowledged_sequence_wr;
  logic acknowledged_block_count_wr;

  assign handshake_idle = (seq_counter == acknowledged_sequence) && (blk_count == acknowledged_block_count);
  assign area_full = (fill_count == BLK_LIMIT);
  // the queue is only drained while filling, so events wait in it meanwhile
  assign q_pop = (state == ELOH_ST_FILL) && q_valid && !area_full;

  assign acknowledged_sequence_wr = i_reg_wr && (i_reg_addr == ELOH_IDX_ACKNOWLEDGED_SEQUENCE);
  assign acknowledged_block_count_wr = i_reg_wr && (i_reg_addr == ELOH_IDX_ACKNOWLEDGED_BLOCK_COUNT);

  always_comb begin
    next_state = state;
    case (state)
      ELOH_ST_IDLE: begin
        if (handshake_idle && q_valid) begin
          next_state = ELOH_ST_FILL;
        end
      end
      ELOH_ST_FILL: begin
        // stop on an empty queue or on a full area
        if (!q_valid || area_full || (q_pop && fill_count == BLK_LIMIT - BW'(1))) begin
          next_state = ELOH_ST_COUNT;
        end
      end
      ELOH_ST_COUNT: begin
        next_state = ELOH_ST_SEQ;
      end
      ELOH_ST_SEQ: begin
        next_state = ELOH_ST_TRANSFER_STATE;
      end
      ELOH_ST_TRANSFER_STATE: begin
        if (handshake_idle) begin
          next_state = ELOH_ST_IDLE;
        end
      end
      default: begin
        next_state = ELOH_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ELOH_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // blocks written so far in the current batch
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_count <= '0;
    end else if (state == ELOH_ST_IDLE) begin
      fill_count <= '0;
    end else if (q_pop) begin
      fill_count <= fill_count + BW'(1);
    end
  end

  // block count first, sequence one cycle later
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      blk_count <= ELOH_RST_BLK_CNT;
    end else if (state == ELOH_ST_COUNT) begin
      blk_count <= 16'(fill_count);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seq_counter <= ELOH_RST_SEQ;
    end else if (state == ELOH_ST_SEQ) begin
      seq_counter <= seq_counter + 16'h0001;
    end
  end

  // acknowledge registers reset to the same values as the counters
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acknowledged_sequence <= ELOH_RST_SEQ;
    end else if (acknowledged_sequence_wr) begin
      acknowledged_sequence <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acknowledged_block_count <= ELOH_RST_BLK_CNT;
    end else if (acknowledged_block_count_wr) begin
      acknowledged_block_count <= i_reg_wdata;
    end
  end

  // ---------------------------------------------------------------------
  // block area: four words written together per popped event
  // ---------------------------------------------------------------------
  logic [15:0] area [AREA_WORDS];
  logic [WW-1:0] blk_base;

  assign blk_base = WW'(fill_count) << 2;

  always_ff @(posedge i_sys_clk) begin
    if (q_pop) begin
      area[blk_base] <= enc_block.w0;
      area[blk_base + WW'(1)] <= enc_block.w1;
      area[blk_base + WW'(2)] <= enc_block.w2;
      area[blk_base + WW'(3)] <= enc_block.w3;
    end
  end

  // ---------------------------------------------------------------------
  // register read decode; area words past the current batch hold stale data
  // ---------------------------------------------------------------------
  logic [15:0] next_rdata;
  logic [15:0] area_off;
  logic ro_hit;

  assign area_off = i_reg_addr - ELOH_IDX_AREA;

  always_comb begin
    next_rdata = 16'h0000;
    if (i_reg_addr == ELOH_IDX_ACKNOWLEDGED_SEQUENCE) begin
      next_rdata = acknowledged_sequence;
    end else if (i_reg_addr == ELOH_IDX_ACKNOWLEDGED_BLOCK_COUNT) begin
      next_rdata = acknowledged_block_count;
    end else if (i_reg_addr == ELOH_IDX_AREA_LEN) begin
      next_rdata = AREA_LEN;
    end else if (i_reg_addr == ELOH_IDX_SEQ) begin
      next_rdata = seq_counter;
    end else if (i_reg_addr == ELOH_IDX_BLK_CNT) begin
      next_rdata = blk_count;
    end else if (i_reg_addr >= ELOH_IDX_AREA && area_off < AREA_LEN) begin
      next_rdata = area[area_off[WW-1:0]];
    end
  end

  // writes to anything but the acknowledge pair are dropped and flagged
  assign ro_hit = i_reg_wr && !acknowledged_sequence_wr && !acknowledged_block_count_wr;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_ack <= 1'b0;
      o_reg_rdata <= 16'h0000;
      o_reg_wr_refused <= 1'b0;
    end else begin
      o_reg_ack <= i_reg_rd || i_reg_wr;
      o_reg_wr_refused <= ro_hit;
      if (i_reg_rd) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  // ---------------------------------------------------------------------
  // status
  // ---------------------------------------------------------------------
  // the sequence matching without the block count means the master acked out of step
  logic next_mismatch;

  assign next_mismatch = (state == ELOH_ST_TRANSFER_STATE) && (seq_counter == acknowledged_sequence) && (blk_count != acknowledged_block_count);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_idle <= 1'b1;
      o_transfer_state <= 1'b0;
      o_batch_blocks <= 16'h0000;
      o_ack_mismatch <= 1'b0;
    end else begin
      o_idle <= (next_state == ELOH_ST_IDLE);
      o_transfer_state <= (next_state == ELOH_ST_TRANSFER_STATE);
      o_batch_blocks <= blk_count;
      if (next_mismatch) begin
        o_ack_mismatch <= 1'b1;
      end else if (state == ELOH_ST_IDLE) begin
        o_ack_mismatch <= 1'b0;
      end
    end
  end
endmodule : eloh_event_log

// [design/eloh_pkg.sv]
// package: constants, types and field layouts of the event log handshake block
package eloh_pkg;

  // register word indices on the register port
  localparam logic [15:0] ELOH_IDX_ACKNOWLEDGED_SEQUENCE = 16'h0000;
  localparam logic [15:0] ELOH_IDX_ACKNOWLEDGED_BLOCK_COUNT = 16'h0001;
  localparam logic [15:0] ELOH_IDX_AREA_LEN = 16'h0004;
  localparam logic [15:0] ELOH_IDX_SEQ = 16'h0005;
  localparam logic [15:0] ELOH_IDX_BLK_CNT = 16'h0006;
  localparam logic [15:0] ELOH_IDX_AREA = 16'h0007;

  localparam int ELOH_WORDS_PER_BLOCK = 4;
  localparam int ELOH_DEF_MAX_BLOCKS = 16;
  localparam int ELOH_DEF_FIFO_DEPTH = 8;

  // startup values
  localparam logic [15:0] ELOH_RST_SEQ = 16'h0000;
  localparam logic [15:0] ELOH_RST_BLK_CNT = 16'h0000;

  // header layout
  localparam int ELOH_HDR_REASON_LSB = 8;
  localparam int ELOH_HDR_KIND_LSB = 0;
  localparam logic [1:0] ELOH_KIND_STAMP = 2'h1;
  localparam logic [1:0] ELOH_KIND_VAR = 2'h2;

  // subfield positions and ranges
  localparam int ELOH_YEAR_LSB = 4;
  localparam int ELOH_DAY_LSB = 11;
  localparam int ELOH_HOUR_LSB = 6;
  localparam int ELOH_SEC_LSB = 10;
  localparam logic [3:0] ELOH_MONTH_MIN = 4'h1;
  localparam logic [3:0] ELOH_MONTH_MAX = 4'hc;
  localparam logic [4:0] ELOH_DAY_MIN = 5'h01;
  localparam logic [4:0] ELOH_DAY_MAX = 5'h1f;
  localparam logic [4:0] ELOH_HOUR_MAX = 5'h17;
  localparam logic [5:0] ELOH_MIN_MAX = 6'h3b;
  localparam logic [5:0] ELOH_SEC_MAX = 6'h3b;
  localparam logic [9:0] ELOH_MILLISECOND_SUBFIELD_MAX = 10'h3e7;

  typedef enum logic [2:0] {
    ELOH_ST_IDLE = 3'b000,
    ELOH_ST_FILL = 3'b001,
    ELOH_ST_COUNT = 3'b011,
    ELOH_ST_SEQ = 3'b010,
    ELOH_ST_TRANSFER_STATE = 3'b110
  } eloh_state_e;

  // one queued event as offered by the producer
  typedef struct packed {
    logic is_stamp;
    logic [3:0] reason;
    logic [11:0] year;
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
    logic [9:0] millisecond_subfield;
    logic [15:0] var_addr;
    logic [15:0] var_value;
    logic is_bool;
  } eloh_event_s;

  typedef struct packed {
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
  } eloh_block_s;

endpackage : eloh_pkg

// [design/eloh_fifo.sv]
// event queue: registered full/empty flags, valid/ready on both sides
`timescale 1ns/1ns
module eloh_fifo import eloh_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("eloh_fifo: depth must be a power of two >= 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;
  logic [AW:0] next_count;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr];

  always_comb begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + (AW + 1)'(1);
    end else if (pop && !push) begin
      next_count = count - (AW + 1)'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
      count <= next_count;
      o_in_ready <= (next_count != (AW + 1)'(DEPTH));
      o_out_valid <= (next_count != '0);
    end
  end
endmodule : eloh_fifo

// [design/eloh_encoder.sv]
// turns one queued event into a four-word data block
`timescale 1ns/1ns
module eloh_encoder import eloh_pkg::*; (
  input wire eloh_event_s i_event,
  output eloh_block_s o_block
);
  logic [3:0] month;
  logic [4:0] day;
  logic [4:0] hour;
  logic [5:0] minute;
  logic [5:0] second;
  logic [9:0] millisecond_subfield;

  // out-of-range inputs saturate so the published fields stay legal
  always_comb begin
    month = i_event.month;
    if (month < ELOH_MONTH_MIN) month = ELOH_MONTH_MIN;
    if (month > ELOH_MONTH_MAX) month = ELOH_MONTH_MAX;
    day = (i_event.day < ELOH_DAY_MIN) ? ELOH_DAY_MIN : i_event.day;
    hour = (i_event.hour > ELOH_HOUR_MAX) ? ELOH_HOUR_MAX : i_event.hour;
    minute = (i_event.minute > ELOH_MIN_MAX) ? ELOH_MIN_MAX : i_event.minute;
    second = (i_event.second > ELOH_SEC_MAX) ? ELOH_SEC_MAX : i_event.second;
    millisecond_subfield = (i_event.millisecond_subfield > ELOH_MILLISECOND_SUBFIELD_MAX) ? ELOH_MILLISECOND_SUBFIELD_MAX : i_event.millisecond_subfield;
    o_block = '0;
    if (i_event.is_stamp) begin
      o_block.w0[ELOH_HDR_REASON_LSB +: 4] = i_event.reason;
      o_block.w0[ELOH_HDR_KIND_LSB +: 2] = ELOH_KIND_STAMP;
      o_block.w1 = {i_event.year, 4'h0} | {12'h000, month};
      o_block.w2[ELOH_DAY_LSB +: 5] = (day > ELOH_DAY_MAX) ? ELOH_DAY_MAX : day;
      o_block.w2[ELOH_HOUR_LSB +: 5] = hour;
      o_block.w2[5:0] = minute;
      o_block.w3[ELOH_SEC_LSB +: 6] = second;
      o_block.w3[9:0] = millisecond_subfield;
    end else begin
      // reason is meaningless here and stays zero; no time words leak in
      o_block.w0[ELOH_HDR_KIND_LSB +: 2] = ELOH_KIND_VAR;
      o_block.w1 = i_event.var_addr;
      o_block.w2 = i_event.is_bool ? {15'h0000, |i_event.var_value} : i_event.var_value;
      o_block.w3 = 16'h0000;
    end
  end
endmodule : eloh_encoder

// [verification/eloh_master.sv]
// partner: register-port master that polls and acknowledges event batches
`timescale 1ns/1ns
module eloh_master import eloh_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reg_ack,
  input wire logic [15:0] i_reg_rdata,
  input wire logic i_reg_wr_refused,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [15:0] o_reg_addr,
  output logic [15:0] o_reg_wdata
);
  initial begin
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_addr = 16'h0000;
    o_reg_wdata = 16'h0000;
  end

  // one-cycle strobe; ack and data sampled one cycle later at the falling edge
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok, output logic rf);
    @(negedge i_sys_clk);
    o_reg_rd = !wr;
    o_reg_wr = wr;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(negedge i_sys_clk);
    // answer stands one cycle only; take it before the release
    ok = i_reg_ack;
    q = i_reg_rdata;
    rf = i_reg_wr_refused;
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    // released lines do not keep the last value
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
    // idle cycle so registered status has settled for the caller
    @(negedge i_sys_clk);
  endtask : access

  task automatic ack_batch(output logic ok);
    logic [15:0] seq, cnt, aseq, ablk;
    logic a, r;
    access(1'b0, ELOH_IDX_SEQ, 16'h0000, seq, a, r);
    ok = a;
    access(1'b0, ELOH_IDX_BLK_CNT, 16'h0000, cnt, a, r);
    ok = ok && a;
    access(1'b0, ELOH_IDX_ACKNOWLEDGED_SEQUENCE, 16'h0000, aseq, a, r);
    access(1'b0, ELOH_IDX_ACKNOWLEDGED_BLOCK_COUNT, 16'h0000, ablk, a, r);
    ok = ok && a && seq != aseq && cnt != ablk;
    if (ok) begin
      access(1'b1, ELOH_IDX_ACKNOWLEDGED_BLOCK_COUNT, cnt, aseq, a, r);
      ok = a;
      access(1'b1, ELOH_IDX_ACKNOWLEDGED_SEQUENCE, seq, aseq, a, r);
      ok = ok && a;
    end
  endtask : ack_batch
endmodule : eloh_master

// [verification/eloh_event_log_props.sv]
// checker: register port and handshake state assertions
`timescale 1ns/1ns
module eloh_event_log_props import eloh_pkg::*; #(
  parameter int MAX_BLOCKS = ELOH_DEF_MAX_BLOCKS
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_evt_valid,
  input wire eloh_event_s i_evt,
  input wire logic o_evt_ready,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic o_reg_ack,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_wr_refused,
  input wire logic o_idle,
  input wire logic o_transfer_state,
  input wire logic [15:0] o_batch_blocks,
  input wire logic o_ack_mismatch
);
  // fill pops at most one block a cycle, then count, sequence and transfer
  localparam int FILL_BOUND = MAX_BLOCKS + 6;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  ack_pulse_a: assert property ((i_reg_rd || i_reg_wr) |=> o_reg_ack)
    else $error("no ack after access");
  ack_quiet_a: assert property (!i_reg_rd && !i_reg_wr |=> !o_reg_ack)
    else $error("ack without access");
  wr_refuse_a: assert property (i_reg_wr && i_reg_addr > 16'h0001 |=> o_reg_wr_refused)
    else $error("write to read-only word not refused");
  wr_accept_a: assert property (i_reg_wr && i_reg_addr <= 16'h0001 |=> !o_reg_wr_refused)
    else $error("acknowledge write refused");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
  state_excl_a: assert property (!(o_idle && o_transfer_state))
    else $error("idle and transfer together");
  fill_bound_a: assert property ($fell(o_idle) |-> ##[1:FILL_BOUND] o_transfer_state)
    else $error("batch not published in time");
  batch_size_a: assert property ($rose(o_transfer_state) |=> o_batch_blocks != 16'h0000 && o_batch_blocks <= MAX_BLOCKS)
    else $error("block count out of range");
  transfer_state_hold_a: assert property (o_transfer_state && $past(o_transfer_state) |-> $stable(o_batch_blocks))
    else $error("block count moved during transfer");
  transfer_state_exit_a: assert property ($fell(o_transfer_state) |-> $past(i_reg_wr) || $past(i_reg_wr, 2) || $past(i_reg_wr, 3))
    else $error("transfer left without acknowledge");
  idle_entry_a: assert property ($rose(o_idle) |-> $past(o_transfer_state))
    else $error("idle entered not from transfer");
endmodule : eloh_event_log_props

// [verification/eloh_event_log_tb.sv]
// testbench: register-port sequences for the event log handshake
`timescale 1ns/1ns
module eloh_event_log_tb import eloh_pkg::*; ;
  // capacity 5 keeps successive block counts distinct for the master
  localparam int MAXB = 5;
  logic clk, rst_n, evt_valid, evt_ready, rd, wr, ack, refused, idle, transfer_state, mism, ok, rf;
  eloh_event_s evt;
  logic [15:0] addr, wdata, rdata, blocks, q;
  int err_total, comparisons;
  logic [15:0] exp1 [4] = '{16'h0301, 16'h7e8c, 16'h0dfb, 16'hefe7};
  logic [15:0] exp2 [8] = '{16'h0002, 16'ha5c3, 16'h0001, 16'h0000, 16'h0002, 16'hbeef, 16'h1234, 16'h0000};
  logic [15:0] ro_idx [3] = '{ELOH_IDX_SEQ, ELOH_IDX_BLK_CNT, ELOH_IDX_AREA};

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  eloh_event_log #(.MAX_BLOCKS(MAXB), .FIFO_DEPTH(8)) i_dut (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_evt_valid(evt_valid), .i_evt(evt), .o_evt_ready(evt_ready), .i_reg_rd(rd), .i_reg_wr(wr),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_ack(ack), .o_reg_rdata(rdata), .o_reg_wr_refused(refused),
    .o_idle(idle), .o_transfer_state(transfer_state), .o_batch_blocks(blocks), .o_ack_mismatch(mism));
  eloh_master i_master (.i_sys_clk(clk), .i_reg_ack(ack), .i_reg_rdata(rdata), .i_reg_wr_refused(refused),
    .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_addr(addr), .o_reg_wdata(wdata));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      err_total++;
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task automatic stall();
    err_total++;
    results();
  endtask : stall

  task automatic rdw(input logic [15:0] a, input logic [15:0] e);
    i_master.access(1'b0, a, 16'h0000, q, ok, rf);
    check("ack", {15'h0000, ok}, 16'h0001);
    check($sformatf("word %h", a), q, e);
  endtask : rdw

  task automatic wrw(input logic [15:0] a, input logic [15:0] d, input logic e);
    i_master.access(1'b1, a, d, q, ok, rf);
    check($sformatf("refusal %h", a), {15'h0000, rf}, {15'h0000, e});
  endtask : wrw

  task automatic push(input eloh_event_s e);
    int n;
    @(negedge clk);
    evt_valid = 1'b1;
    evt = e;
    n = 0;
    while (evt_ready !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 50) stall();
    end
    @(negedge clk);
    evt_valid = 1'b0;
  endtask : push

  // polls the sequence word like the master does; bounded
  task automatic poll_seq(input logic [15:0] e);
    int n;
    n = 0;
    q = 16'hffff;
    while (q !== e) begin
      i_master.access(1'b0, ELOH_IDX_SEQ, 16'h0000, q, ok, rf);
      n++;
      if (n > 40) stall();
    end
  endtask : poll_seq

  function automatic eloh_event_s mk_var(input logic [15:0] a, input logic [15:0] v, input logic b);
    return eloh_event_s'{var_addr: a, var_value: v, is_bool: b, default: '0};
  endfunction : mk_var

  initial begin
    rst_n = 1'b0;
    evt_valid = 1'b0;
    evt = '0;
    err_total = 0;
    comparisons = 0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    check("idle", {15'h0000, idle}, 16'h0001);
    rdw(ELOH_IDX_SEQ, ELOH_RST_SEQ);
    rdw(ELOH_IDX_BLK_CNT, ELOH_RST_BLK_CNT);
    rdw(ELOH_IDX_ACKNOWLEDGED_SEQUENCE, ELOH_RST_SEQ);
    rdw(ELOH_IDX_ACKNOWLEDGED_BLOCK_COUNT, ELOH_RST_BLK_CNT);
    rdw(ELOH_IDX_AREA_LEN, 16'(MAXB * ELOH_WORDS_PER_BLOCK));
    rdw(16'h0002, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      wrw(ro_idx[i], 16'h0003, 1'b1);
    end
    rdw(ELOH_IDX_SEQ, ELOH_RST_SEQ);
    rdw(ELOH_IDX_BLK_CNT, ELOH_RST_BLK_CNT);
    $display("test reset and refusal done");
    // out-of-range time fields probe the clamps
    push(eloh_event_s'{is_stamp: 1'b1, reason: 4'h3, year: 12'h7e8, month: 4'hf, day: 5'h00, hour: 5'h1f,
      minute: 6'h3f, second: 6'h3f, millisecond_subfield: 10'h3ff, default: '0});
    poll_seq(16'h0001);
    rdw(ELOH_IDX_BLK_CNT, 16'h0001);
    check("batch blocks", blocks, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      rdw(ELOH_IDX_AREA + 16'(i), exp1[i]);
    end
    push(mk_var(16'ha5c3, 16'h0055, 1'b1));
    push(mk_var(16'hbeef, 16'h1234, 1'b0));
    repeat (8) @(negedge clk);
    rdw(ELOH_IDX_SEQ, 16'h0001);
    // queued events are not written before the acknowledge; the stamp block must survive
    rdw(ELOH_IDX_AREA + 16'h0001, exp1[1]);
    wrw(ELOH_IDX_ACKNOWLEDGED_SEQUENCE, 16'h0001, 1'b0);
    check("mismatch", {15'h0000, mism}, 16'h0001);
    check("transfer_state", {15'h0000, transfer_state}, 16'h0001);
    wrw(ELOH_IDX_ACKNOWLEDGED_BLOCK_COUNT, 16'h0001, 1'b0);
    poll_seq(16'h0002);
    rdw(ELOH_IDX_BLK_CNT, 16'h0002);
    for (int i = 0; i < 8; i++) begin
      rdw(ELOH_IDX_AREA + 16'(i), exp2[i]);
    end
    $display("test batch encoding done");
    for (int i = 0; i < 8; i++) begin
      push(mk_var(16'h0100 + 16'(i), 16'(i), 1'b0));
    end
    @(negedge clk);
    check("ready", {15'h0000, evt_ready}, 16'h0000);
    i_master.ack_batch(ok);
    check("ack batch", {15'h0000, ok}, 16'h0001);
    poll_seq(16'h0003);
    rdw(ELOH_IDX_BLK_CNT, 16'h0005);
    check("batch blocks", blocks, 16'h0005);
    rdw(ELOH_IDX_AREA + 16'h0011, 16'h0104);
    i_master.ack_batch(ok);
    check("ack batch", {15'h0000, ok}, 16'h0001);
    poll_seq(16'h0004);
    rdw(ELOH_IDX_BLK_CNT, 16'h0003);
    rdw(ELOH_IDX_AREA + 16'h0001, 16'h0105);
    i_master.ack_batch(ok);
    check("ack batch", {15'h0000, ok}, 16'h0001);
    repeat (4) @(negedge clk);
    check("idle", {15'h0000, idle}, 16'h0001);
    check("transfer_state", {15'h0000, transfer_state}, 16'h0000);
    check("mismatch clear", {15'h0000, mism}, 16'h0000);
    check("ready", {15'h0000, evt_ready}, 16'h0001);
    $display("test queue fill and drain done");
    results();
  end
endmodule : eloh_event_log_tb

bind eloh_event_log eloh_event_log_props #(.MAX_BLOCKS(MAX_BLOCKS)) i_props (.i_sys_clk(i_sys_clk),
  .i_rst_n(i_rst_n), .i_evt_valid(i_evt_valid), .i_evt(i_evt), .o_evt_ready(o_evt_ready),
  .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_reg_ack(o_reg_ack), .o_reg_rdata(o_reg_rdata), .o_reg_wr_refused(o_reg_wr_refused), .o_idle(o_idle),
  .o_transfer_state(o_transfer_state), .o_batch_blocks(o_batch_blocks), .o_ack_mismatch(o_ack_mismatch));
